/* rtl/flash_seq_defines.vh */
// Constants for the dual-bank flash command sequencer.
`ifndef FLASH_SEQ_DEFINES_VH
`define FLASH_SEQ_DEFINES_VH
// Clock period and the times that become cycle counts.
`define CLK_NS 10
`define ERASE_WIN_US 80
`define CMD_TO_US 80
`define NS_PER_US 1000
`define TMR_W 14
// Widths of the bus and of the sector select groups.
`define ADDR_W 16
`define ADDR_TOP 15
`define DEC_TOP 11
`define PRI_N 8
`define SEC_N 4
// Unlock cycles: data and decoded offset.
`define A_UL1 12'h555
`define A_UL2 12'haaa
`define D_UL1 8'haa
`define D_UL2 8'h55
// Command bytes.
`define C_ID 8'h90
`define C_PROG 8'ha0
`define C_ERASE 8'h80
`define C_SECT 8'h30
`define C_BULK 8'h10
`define C_SUSP 8'hb0
`define C_RESUME 8'h30
`define C_RESET 8'hf0
`define C_BYP 8'h20
`define C_BYP_EXIT 8'h00
// Identify-mode read offsets (low two address bits) and answers.
`define RD_IDENT 2'h1
`define RD_PROT 2'h2
`define IDENT_CODE 8'h5a
`define PROT_YES 8'h01
`define PROT_NO 8'h00
// Sector masks for a bulk erase of each array.
`define ALL_PRI 8'hff
`define ALL_SEC 8'h0f
`endif

/* rtl/dual_flash_command_sequencer.v */
// Command decoder and sequencer for a dual-bank flash block.
`timescale 1ns/10ps
`include "flash_seq_defines.vh"

module dual_flash_command_sequencer #(
   parameter [`TMR_W-1:0] ERASE_WIN_CYC = `ERASE_WIN_US * `NS_PER_US / `CLK_NS,
   parameter [`TMR_W-1:0] CMD_TO_CYC = `CMD_TO_US * `NS_PER_US / `CLK_NS
) (
   // Clock and reset
   input wire i_clk,
   input wire i_rst,
   // Host bus pins
   input wire i_write_strobe_input_n,
   input wire [`ADDR_W-1:0] i_addr,
   input wire [7:0] i_data,
   input wire [`PRI_N-1:0] i_primary_sector_selects,
   input wire [`SEC_N-1:0] i_secondary_sector_selects,
   input wire i_half_block_select,
   // Configuration and protection state
   input wire i_half_cfg,
   input wire [`PRI_N-1:0] i_prot_primary,
   input wire [`SEC_N-1:0] i_prot_secondary,
   // Array core handshake
   input wire i_op_done,
   input wire i_op_error,
   // Read path
   output reg [`ADDR_W-1:0] o_array_addr,
   output reg o_rd_src,
   output reg [7:0] o_rd_data,
   // Status
   output reg o_ready_busy_pin,
   output reg o_error_flag_bit,
   // Array core commands
   output reg o_prog,
   output reg o_erase,
   output reg o_suspend,
   output reg o_op_bank,
   output reg [`ADDR_W-1:0] o_op_addr,
   output reg [7:0] o_op_data,
   output reg [`PRI_N-1:0] o_erase_mask
);

   localparam [3:0] ST_READ = 4'h0;
   localparam [3:0] ST_UL1 = 4'h1;
   localparam [3:0] ST_UL2 = 4'h2;
   localparam [3:0] ST_ID = 4'h3;
   localparam [3:0] ST_PADDR = 4'h4;
   localparam [3:0] ST_PROG = 4'h5;
   localparam [3:0] ST_E80 = 4'h6;
   localparam [3:0] ST_EUL1 = 4'h7;
   localparam [3:0] ST_EUL2 = 4'h8;
   localparam [3:0] ST_EQ = 4'h9;
   localparam [3:0] ST_ERASING = 4'ha;
   localparam [3:0] ST_SUSP = 4'hb;
   localparam [3:0] ST_BYP = 4'hc;
   localparam [3:0] ST_BYPX = 4'hd;
   localparam [3:0] ST_ERR = 4'he;

   // Widens the selected array's sector vector to a common eight-bit mask.
   function [`PRI_N-1:0] sect_mask;
      input pri;
      input [`PRI_N-1:0] p;
      input [`SEC_N-1:0] s;
      begin
         sect_mask = pri ? p : {{(`PRI_N-`SEC_N){1'b0}}, s};
      end
   endfunction

   reg [2:0] wr_sync_r;
   reg wr_lvl_r;
   reg [`ADDR_W-1:0] addr_s1_r;
   reg [`ADDR_W-1:0] addr_s2_r;
   reg [7:0] data_s1_r;
   reg [7:0] data_s2_r;
   reg [`PRI_N-1:0] psel_s1_r;
   reg [`PRI_N-1:0] psel_s2_r;
   reg [`SEC_N-1:0] ssel_s1_r;
   reg [`SEC_N-1:0] ssel_s2_r;
   reg half_s1_r;
   reg half_s2_r;
   reg [`ADDR_W-1:0] cap_addr_r;
   reg [`PRI_N-1:0] cap_psel_r;
   reg [`SEC_N-1:0] cap_ssel_r;
   reg [3:0] st_r;
   reg byp_r;
   reg bulk_r;
   reg [`TMR_W-1:0] tmr_r;

   // The strobe passes three flops; a level counts once the last two agree.
   // Bus lines pass two flops so they line up with the settled strobe.
   always @(posedge i_clk) begin
      if (i_rst) begin
         wr_sync_r <= 3'h7;
         wr_lvl_r <= 1'b1;
         addr_s1_r <= {`ADDR_W{1'b0}};
         addr_s2_r <= {`ADDR_W{1'b0}};
         data_s1_r <= 8'h00;
         data_s2_r <= 8'h00;
         psel_s1_r <= {`PRI_N{1'b0}};
         psel_s2_r <= {`PRI_N{1'b0}};
         ssel_s1_r <= {`SEC_N{1'b0}};
         ssel_s2_r <= {`SEC_N{1'b0}};
         half_s1_r <= 1'b0;
         half_s2_r <= 1'b0;
      end else begin
         wr_sync_r <= {wr_sync_r[1:0], i_write_strobe_input_n};
         if (wr_sync_r[1] == wr_sync_r[2]) begin
            wr_lvl_r <= wr_sync_r[2];
         end
         addr_s1_r <= i_addr;
         addr_s2_r <= addr_s1_r;
         data_s1_r <= i_data;
         data_s2_r <= data_s1_r;
         psel_s1_r <= i_primary_sector_selects;
         psel_s2_r <= psel_s1_r;
         ssel_s1_r <= i_secondary_sector_selects;
         ssel_s2_r <= ssel_s1_r;
         half_s1_r <= i_half_block_select;
         half_s2_r <= half_s1_r;
      end
   end

   wire agree = (wr_sync_r[1] == wr_sync_r[2]);
   wire wr_fall = agree & wr_lvl_r & ~wr_sync_r[2];
   wire wr_rise = agree & ~wr_lvl_r & wr_sync_r[2];

   // Address and selects are frozen at the falling strobe edge.
   always @(posedge i_clk) begin
      if (i_rst) begin
         cap_addr_r <= {`ADDR_W{1'b0}};
         cap_psel_r <= {`PRI_N{1'b0}};
         cap_ssel_r <= {`SEC_N{1'b0}};
      end else if (wr_fall) begin
         cap_addr_r <= addr_s2_r;
         cap_psel_r <= psel_s2_r;
         cap_ssel_r <= ssel_s2_r;
      end
   end

   // A write event is the rising edge, carrying the data seen at that edge.
   wire ev_pri = |cap_psel_r;
   wire ev = wr_rise & (ev_pri | (|cap_ssel_r));
   wire [7:0] d = data_s2_r;
   wire [`DEC_TOP:0] a = cap_addr_r[`DEC_TOP:0];
   wire [`PRI_N-1:0] ev_mask = sect_mask(ev_pri, cap_psel_r, cap_ssel_r);
   wire [`PRI_N-1:0] prot_vec = sect_mask(ev_pri, i_prot_primary, i_prot_secondary);
   wire ev_prot = |(ev_mask & prot_vec);
   wire [`PRI_N-1:0] ok_mask = ev_mask & ~prot_vec;
   wire at555 = (a == `A_UL1);
   wire is_ul1 = at555 && (d == `D_UL1);
   wire is_ul2 = (a == `A_UL2) && (d == `D_UL2);
   wire same_bank = (ev_pri == o_op_bank);
   wire hit_erasing = o_suspend & same_bank & (|(ev_mask & o_erase_mask));
   wire [3:0] home = o_suspend ? ST_SUSP : ST_READ;
   wire decoding = (st_r == ST_UL1) || (st_r == ST_UL2) || (st_r == ST_PADDR) ||
                   (st_r == ST_E80) || (st_r == ST_EUL1) || (st_r == ST_EUL2) ||
                   (st_r == ST_BYPX);
   wire cmd_to = decoding && (tmr_r >= CMD_TO_CYC);
   wire win_end = (st_r == ST_EQ) && (tmr_r >= ERASE_WIN_CYC);

   // Sequencer.  Array contents change only through the start of a decoded
   // program or erase, never through a bare write.
   always @(posedge i_clk) begin
      if (i_rst) begin
         st_r <= ST_READ;
         byp_r <= 1'b0;
         bulk_r <= 1'b0;
         tmr_r <= {`TMR_W{1'b0}};
         o_error_flag_bit <= 1'b0;
         o_prog <= 1'b0;
         o_erase <= 1'b0;
         o_suspend <= 1'b0;
         o_op_bank <= 1'b0;
         o_op_addr <= {`ADDR_W{1'b0}};
         o_op_data <= 8'h00;
         o_erase_mask <= {`PRI_N{1'b0}};
      end else begin
         // The gap timer restarts on every accepted byte.
         if (ev) begin
            tmr_r <= {`TMR_W{1'b0}};
         end else if (tmr_r != {`TMR_W{1'b1}}) begin
            tmr_r <= tmr_r + 1'b1;
         end
         if (cmd_to) begin
            // A stalled bypass program must not leave bypass armed in read mode.
            byp_r <= 1'b0;
            st_r <= home;
         end else begin
            case (st_r)
               ST_READ, ST_SUSP: begin
                  // Plain writes here are dropped, so reads stay ROM-like.
                  if (ev && st_r == ST_SUSP && d == `C_RESUME) begin
                     o_suspend <= 1'b0;
                     st_r <= ST_ERASING;
                  end else if (ev && is_ul1) begin
                     st_r <= ST_UL1;
                  end
               end
               ST_UL1: begin
                  if (ev) begin
                     st_r <= is_ul2 ? ST_UL2 : home;
                  end
               end
               ST_UL2: begin
                  if (ev) begin
                     if (at555 && d == `C_ID) begin
                        st_r <= ST_ID;
                     end else if (at555 && d == `C_PROG) begin
                        st_r <= ST_PADDR;
                     end else if (at555 && d == `C_ERASE && !o_suspend) begin
                        st_r <= ST_E80;
                     end else if (at555 && d == `C_BYP && !o_suspend) begin
                        st_r <= ST_BYP;
                     end else begin
                        st_r <= home;
                     end
                  end
               end
               ST_ID: begin
                  if (ev && d == `C_RESET) begin
                     st_r <= home;
                  end
               end
               ST_PADDR: begin
                  if (ev) begin
                     if (ev_prot || hit_erasing) begin
                        st_r <= byp_r ? ST_BYP : home;
                     end else begin
                        o_prog <= 1'b1;
                        o_op_addr <= cap_addr_r;
                        o_op_data <= d;
                        if (!o_suspend) begin
                           o_op_bank <= ev_pri;
                        end
                        st_r <= ST_PROG;
                     end
                  end
               end
               ST_PROG: begin
                  if (i_op_done) begin
                     o_prog <= 1'b0;
                     if (i_op_error) begin
                        o_error_flag_bit <= 1'b1;
                        st_r <= ST_ERR;
                     end else begin
                        st_r <= byp_r ? ST_BYP : home;
                     end
                  end
               end
               ST_E80: begin
                  if (ev) begin
                     st_r <= is_ul1 ? ST_EUL1 : ST_READ;
                  end
               end
               ST_EUL1: begin
                  if (ev) begin
                     st_r <= is_ul2 ? ST_EUL2 : ST_READ;
                  end
               end
               ST_EUL2: begin
                  if (ev) begin
                     o_op_bank <= ev_pri;
                     o_op_addr <= cap_addr_r;
                     bulk_r <= (d == `C_BULK);
                     if (d == `C_SECT) begin
                        o_erase_mask <= ok_mask;
                        st_r <= ST_EQ;
                     end else if (at555 && d == `C_BULK) begin
                        o_erase_mask <= (ev_pri ? `ALL_PRI : `ALL_SEC) & ~prot_vec;
                        o_erase <= 1'b1;
                        st_r <= ST_ERASING;
                     end else begin
                        st_r <= ST_READ;
                     end
                  end
               end
               ST_EQ: begin
                  if (ev && d == `C_SECT && same_bank) begin
                     o_erase_mask <= o_erase_mask | ok_mask;
                  end else if (ev) begin
                     o_erase_mask <= {`PRI_N{1'b0}};
                     st_r <= ST_READ;
                  end else if (win_end) begin
                     o_erase <= 1'b1;
                     st_r <= ST_ERASING;
                  end
               end
               ST_ERASING: begin
                  // An all-protected request still raises o_erase with an empty mask and waits here for i_op_done.
                  if (!o_erase || i_op_done) begin
                     o_erase <= 1'b0;
                     o_erase_mask <= {`PRI_N{1'b0}};
                     o_error_flag_bit <= o_erase & i_op_error;
                     st_r <= (o_erase & i_op_error) ? ST_ERR : ST_READ;
                  end else if (ev && d == `C_SUSP && !bulk_r) begin
                     // Only a sector erase may be suspended; a bulk erase runs on.
                     o_suspend <= 1'b1;
                     st_r <= ST_SUSP;
                  end
               end
               ST_BYP: begin
                  byp_r <= 1'b1;
                  if (ev && d == `C_PROG) begin
                     st_r <= ST_PADDR;
                  end else if (ev && d == `C_ID) begin
                     st_r <= ST_BYPX;
                  end else if (ev) begin
                     byp_r <= 1'b0;
                     st_r <= ST_READ;
                  end
               end
               ST_BYPX: begin
                  if (ev) begin
                     byp_r <= 1'b0;
                     st_r <= (d == `C_BYP_EXIT) ? ST_READ : ST_BYP;
                  end
               end
               ST_ERR: begin
                  if (ev && d == `C_RESET) begin
                     o_error_flag_bit <= 1'b0;
                     st_r <= ST_READ;
                  end
               end
               default: begin
                  st_r <= ST_READ;
               end
            endcase
         end
      end
   end

   // Read path and status pins, one cycle behind the state and bus.
   // The half-select only steers the read address; programs take the captured bus
   // address and the erase mask is whole sectors, so neither uses it.
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_array_addr <= {`ADDR_W{1'b0}};
         o_rd_src <= 1'b0;
         o_rd_data <= 8'h00;
         o_ready_busy_pin <= 1'b1;
      end else begin
         o_array_addr <= {i_half_cfg ? half_s2_r : addr_s2_r[`ADDR_TOP],
                          addr_s2_r[`ADDR_TOP-1:0]};
         o_rd_src <= (st_r == ST_ID);
         if (addr_s2_r[1:0] == `RD_IDENT) begin
            o_rd_data <= `IDENT_CODE;
         end else if (addr_s2_r[1:0] == `RD_PROT &&
                      (|(sect_mask(|psel_s2_r, psel_s2_r, ssel_s2_r) &
                         sect_mask(|psel_s2_r, i_prot_primary, i_prot_secondary)))) begin
            o_rd_data <= `PROT_YES;
         end else begin
            o_rd_data <= `PROT_NO;
         end
         o_ready_busy_pin <= ~((st_r == ST_PROG) || (st_r == ST_ERASING));
      end
   end

endmodule // dual_flash_command_sequencer

/* test/dual_flash_command_sequencer_properties.sv */
// Concurrent checks on the ports of the flash command sequencer.
`timescale 1ns/10ps
`include "flash_seq_defines.vh"
module dual_flash_command_sequencer_properties #(
   parameter [`TMR_W-1:0] ERASE_WIN_CYC = 20
) (
   // Clock and reset
   input wire i_clk,
   input wire i_rst,
   // Watched inputs
   input wire i_write_strobe_input_n,
   input wire [`ADDR_W-1:0] i_addr,
   input wire i_half_block_select,
   input wire i_half_cfg,
   input wire i_op_done,
   // Watched outputs
   input wire [`ADDR_W-1:0] o_array_addr,
   input wire o_rd_src,
   input wire [7:0] o_rd_data,
   input wire o_ready_busy_pin,
   input wire o_error_flag_bit,
   input wire o_prog,
   input wire o_erase,
   input wire o_suspend
);
   reg [15:0] since_wr_r;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Cycles since the strobe pin was last low; it saturates rather than wrap.
   always @(posedge i_clk) begin
      if (i_rst || !i_write_strobe_input_n) begin
         since_wr_r <= 16'h0000;
      end else if (since_wr_r != 16'hffff) begin
         since_wr_r <= since_wr_r + 16'h0001;
      end
   end
   // A write has just completed its strobe and pipeline.
   sequence s_fresh_write;
      since_wr_r < 16'h000c;
   endsequence
   // Top address bit and half-select inputs held long enough to fill the pipeline.
   sequence s_steady;
      ($stable(i_half_cfg) && $stable(i_half_block_select) && $stable(i_addr[15])) [*4];
   endsequence
   a_busy_follows: assert property ($rose(o_prog) |=> !o_ready_busy_pin)
      else $error("Ready stayed high after a program started.");
   a_ready_idle: assert property ((!o_prog && !o_erase && !$past(o_prog) && !$past(o_erase)) |-> o_ready_busy_pin)
      else $error("Busy shown with no operation running.");
   a_prog_done: assert property ((o_prog && i_op_done) |=> !o_prog)
      else $error("Program stayed active after completion.");
   a_prog_cause: assert property ($rose(o_prog) |-> s_fresh_write)
      else $error("Program started without a bus write.");
   a_erase_cause: assert property ($rose(o_erase) |-> since_wr_r <= ERASE_WIN_CYC + 16'h000c)
      else $error("Erase started outside its window after a write.");
   a_susp_in_erase: assert property (o_suspend |-> o_erase)
      else $error("Suspend shown without an erase.");
   a_err_clear: assert property ($fell(o_error_flag_bit) |-> s_fresh_write)
      else $error("Error flag cleared without a write.");
   a_ident_enter: assert property ($rose(o_rd_src) |-> s_fresh_write)
      else $error("Identify mode entered without a write.");
   a_ident_data: assert property ((o_rd_src && $past(o_rd_src, 3) && $past(i_addr[1:0], 3) == `RD_IDENT && $past(i_addr[1:0], 2) == `RD_IDENT) |-> o_rd_data == `IDENT_CODE)
      else $error("Identifier read returned a wrong value.");
   a_top_bit: assert property (s_steady |-> o_array_addr[15] == (i_half_cfg ? i_half_block_select : i_addr[15]))
      else $error("Top array address bit has the wrong source.");
endmodule // dual_flash_command_sequencer_properties

/* test/array_core_model.sv */
// Behavioural array core that answers program and erase commands.
`timescale 1ns/10ps
module array_core_model #(
   parameter LAT = 100
) (
   // Clock and reset
   input wire i_clk,
   input wire i_rst,
   // Commands from the sequencer and the bench's failure request
   input wire i_prog,
   input wire i_erase,
   input wire i_suspend,
   input wire i_fail,
   // Completion handshake
   output reg o_done,
   output reg o_error
);
   reg [9:0] cnt_r;
   // Counts work cycles; the error line toggles when it carries no meaning.
   always @(posedge i_clk) begin
      o_done <= 1'b0;
      o_error <= i_rst ? 1'b0 : ~o_error;
      if (i_rst || !(i_prog || i_erase)) begin
         cnt_r <= 10'h000;
      end else if (!(i_erase && i_suspend && !i_prog)) begin
         cnt_r <= cnt_r + 10'h001;
         if (cnt_r == LAT) begin
            o_done <= 1'b1;
            o_error <= i_fail;
            cnt_r <= 10'h000;
         end
      end
   end
endmodule // array_core_model

/* test/dual_flash_command_sequencer_tb_top.sv */
// Self-checking bench for the flash command sequencer.
`timescale 1ns/10ps
`include "flash_seq_defines.vh"
module dual_flash_command_sequencer_tb_top;
   localparam [`TMR_W-1:0] EW = 20;
   localparam [`TMR_W-1:0] TO = 40;
   reg i_clk = 1'b0;
   reg i_rst = 1'b1;
   reg wr_n = 1'b1;
   reg [15:0] addr = 16'h0000;
   reg [7:0] data = 8'h00;
   reg [7:0] psel = 8'h00;
   reg [3:0] ssel = 4'h0;
   reg hsel = 1'b0;
   reg hcfg = 1'b0;
   reg [7:0] pprot = 8'h00;
   reg [3:0] sprot = 4'h0;
   reg fail = 1'b0;
   wire done, op_err, rsrc, ready, errf, prog, erase, susp, bank;
   wire [15:0] aaddr, oaddr;
   wire [7:0] rdat, odat, emask;
   integer errors = 0;
   integer comparisons = 0;
   integer i;
   // Free-running 100 MHz clock.
   initial forever #5 i_clk = ~i_clk;
   dual_flash_command_sequencer #(.ERASE_WIN_CYC(EW), .CMD_TO_CYC(TO))
      dual_flash_command_sequencer_inst (.i_clk(i_clk), .i_rst(i_rst),
      .i_write_strobe_input_n(wr_n), .i_addr(addr), .i_data(data),
      .i_primary_sector_selects(psel), .i_secondary_sector_selects(ssel),
      .i_half_block_select(hsel), .i_half_cfg(hcfg), .i_prot_primary(pprot),
      .i_prot_secondary(sprot), .i_op_done(done), .i_op_error(op_err),
      .o_array_addr(aaddr), .o_rd_src(rsrc), .o_rd_data(rdat), .o_ready_busy_pin(ready),
      .o_error_flag_bit(errf), .o_prog(prog), .o_erase(erase), .o_suspend(susp),
      .o_op_bank(bank), .o_op_addr(oaddr), .o_op_data(odat), .o_erase_mask(emask));
   array_core_model #(.LAT(100)) array_core_model_inst (.i_clk(i_clk), .i_rst(i_rst),
      .i_prog(prog), .i_erase(erase), .i_suspend(susp), .i_fail(fail),
      .o_done(done), .o_error(op_err));
   // Compares one result and reports a mismatch at once.
   task chk(input [15:0] got, input [15:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // One bus write; data is wrong at the strobe fall and right at its rise, and
   // the address changes once the strobe rises, so each is taken at its own edge.
   task wr(input [15:0] a, input [7:0] d);
      begin
         addr = a;
         data = ~d;
         wr_n = 1'b0;
         repeat (2) @(negedge i_clk);
         data = d;
         repeat (2) @(negedge i_clk);
         wr_n = 1'b1;
         addr = ~a;
         repeat (4) @(negedge i_clk);
         data = ~d;
         @(negedge i_clk);
      end
   endtask
   // Unlock pair with high address bits that decoding must ignore.
   task ul;
      begin
         wr(16'hf555, `D_UL1);
         wr(16'h7aaa, `D_UL2);
      end
   endtask
   // Full byte program sequence.
   task prog_seq(input [15:0] a, input [7:0] d);
      begin
         ul;
         wr(16'h0555, `C_PROG);
         wr(a, d);
      end
   endtask
   // Waits, bounded, until no program or erase is running.
   task wdone;
      begin
         for (i = 0; i < 400 && (prog !== 1'b0 || erase !== 1'b0); i = i + 1)
            @(negedge i_clk);
         repeat (2) @(negedge i_clk);
      end
   endtask
   // Read mode after reset, plain writes and the half-select source.
   task s_read;
      begin
         chk(ready, 1'b1);
         chk(rsrc, 1'b0);
         psel = 8'h01;
         wr(16'h1234, 8'h3c);
         repeat (20) @(negedge i_clk);
         chk(prog, 1'b0);
         psel = 8'h80;
         hcfg = 1'b1;
         hsel = 1'b1;
         addr = 16'h0000;
         repeat (6) @(negedge i_clk);
         chk(aaddr, 16'h8000);
         hcfg = 1'b0;
         addr = 16'h8000;
         hsel = 1'b0;
         repeat (6) @(negedge i_clk);
         chk(aaddr, 16'h8000);
      end
   endtask
   // Program, then a failing program that must latch the error flag.
   task s_prog;
      begin
         psel = 8'h10;
         prog_seq(16'h4321, 8'h7e);
         chk(prog, 1'b1);
         chk(oaddr, 16'h4321);
         chk(odat, 8'h7e);
         chk(bank, 1'b1);
         chk(ready, 1'b0);
         wdone;
         chk(ready, 1'b1);
         fail = 1'b1;
         prog_seq(16'h0010, 8'h01);
         wdone;
         chk(errf, 1'b1);
         wr(16'h0000, `C_RESET);
         chk(errf, 1'b0);
         fail = 1'b0;
      end
   endtask
   // Programs to a protected sector and with no select must be ignored.
   task s_refuse;
      begin
         pprot = 8'h04;
         psel = 8'h04;
         prog_seq(16'h0020, 8'h55);
         chk(prog, 1'b0);
         psel = 8'h00;
         pprot = 8'h00;
         prog_seq(16'h0020, 8'h55);
         chk(prog, 1'b0);
      end
   endtask
   // Identifier and protection reads on the secondary array, left by reset command.
   task s_ident;
      begin
         ssel = 4'h2;
         sprot = 4'h4;
         ul;
         wr(16'h0555, `C_ID);
         chk(rsrc, 1'b1);
         addr = 16'h0001;
         repeat (5) @(negedge i_clk);
         chk(rdat, `IDENT_CODE);
         addr = 16'h0002;
         repeat (5) @(negedge i_clk);
         chk(rdat, `PROT_NO);
         ssel = 4'h4;
         repeat (5) @(negedge i_clk);
         chk(rdat, `PROT_YES);
         chk(rsrc, 1'b1);
         wr(16'h3000, `C_RESET);
         chk(rsrc, 1'b0);
         ssel = 4'h0;
         sprot = 4'h0;
      end
   endtask
   // Queued sector erase with suspend, resume and both commands out of place.
   task s_erase;
      begin
         hcfg = 1'b1;
         hsel = 1'b1;
         psel = 8'h01;
         ul;
         wr(16'h0555, `C_ERASE);
         ul;
         wr(16'h0000, `C_SECT);
         psel = 8'h08;
         wr(16'h8000, `C_SECT);
         for (i = 0; i < 60 && erase !== 1'b1; i = i + 1)
            @(negedge i_clk);
         chk(emask, 8'h09);
         @(negedge i_clk);
         chk(ready, 1'b0);
         wr(16'h0123, `C_SUSP);
         chk(susp, 1'b1);
         // While suspended, the erasing sector refuses a program, another takes it.
         psel = 8'h08;
         prog_seq(16'h0200, 8'h44);
         chk(prog, 1'b0);
         psel = 8'h02;
         prog_seq(16'h0200, 8'h44);
         chk(prog, 1'b1);
         for (i = 0; i < 200 && prog !== 1'b0; i = i + 1)
            @(negedge i_clk);
         chk(susp, 1'b1);
         wr(16'h0456, `C_RESUME);
         chk(susp, 1'b0);
         wdone;
         wr(16'h0000, `C_SUSP);
         chk(susp, 1'b0);
         wr(16'h0000, `C_RESUME);
         chk(erase, 1'b0);
         hcfg = 1'b0;
      end
   endtask
   // Bulk erase spares the protected sector.
   task s_bulk;
      begin
         pprot = 8'h04;
         psel = 8'h01;
         ul;
         wr(16'h0555, `C_ERASE);
         ul;
         wr(16'h0555, `C_BULK);
         for (i = 0; i < 20 && erase !== 1'b1; i = i + 1)
            @(negedge i_clk);
         chk(emask, `ALL_PRI & ~8'h04);
         wr(16'h0000, `C_SUSP);
         chk(susp, 1'b0);
         wdone;
         pprot = 8'h00;
      end
   endtask
   // Unlock bypass program, exit, then a program byte that must be refused.
   task s_bypass;
      begin
         psel = 8'h00;
         ssel = 4'h1;
         ul;
         wr(16'h0555, `C_BYP);
         wr(16'h0777, `C_PROG);
         wr(16'h2222, 8'h11);
         chk(prog, 1'b1);
         chk(bank, 1'b0);
         chk(oaddr, 16'h2222);
         wdone;
         wr(16'h0000, `C_ID);
         wr(16'h0000, `C_BYP_EXIT);
         wr(16'h0000, `C_PROG);
         wr(16'h2222, 8'h11);
         chk(prog, 1'b0);
      end
   endtask
   // A byte gap over the time-out and an invalid byte both abandon decoding.
   task s_abort;
      begin
         wr(16'h0555, `D_UL1);
         repeat (TO + 10) @(negedge i_clk);
         wr(16'h0aaa, `D_UL2);
         wr(16'h0555, `C_PROG);
         wr(16'h0100, 8'h22);
         chk(prog, 1'b0);
         ul;
         wr(16'h0555, 8'h77);
         wr(16'h0555, `C_PROG);
         wr(16'h0100, 8'h22);
         chk(prog, 1'b0);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task end_sim;
      begin
         $display("errors %0d comparisons %0d", errors, comparisons);
         if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // Main sequence after twelve cycles of reset.
   initial begin
      repeat (12) @(negedge i_clk);
      i_rst = 1'b0;
      @(negedge i_clk);
      s_read;
      s_prog;
      s_refuse;
      s_ident;
      s_erase;
      s_bulk;
      s_bypass;
      s_abort;
      end_sim;
   end
   // Watchdog well beyond the fewer than two thousand cycles the tests need.
   initial begin
      #500000;
      errors = errors + 1;
      end_sim;
   end
endmodule // dual_flash_command_sequencer_tb_top
bind dual_flash_command_sequencer dual_flash_command_sequencer_properties #(
   .ERASE_WIN_CYC(ERASE_WIN_CYC)) props_inst (.i_clk(i_clk), .i_rst(i_rst),
   .i_write_strobe_input_n(i_write_strobe_input_n), .i_addr(i_addr),
   .i_half_block_select(i_half_block_select), .i_half_cfg(i_half_cfg),
   .i_op_done(i_op_done), .o_array_addr(o_array_addr), .o_rd_src(o_rd_src),
   .o_rd_data(o_rd_data), .o_ready_busy_pin(o_ready_busy_pin),
   .o_error_flag_bit(o_error_flag_bit), .o_prog(o_prog), .o_erase(o_erase),
   .o_suspend(o_suspend));
